// [logic/mvx_core.sv]
/*
 * execution, cycle accounting and external bus sequencing for the
 * move instruction group.
 * assumes the decoder holds req stable while busy, and that external
 * memory answers on the multiplexed bus clocked from the core clock.
 */
`timescale 1ns/1ps

// Behaviour
// RULE1 - high-immediate writes imm into dword bits 31:16; 5B/3S binary, 4B/2S source
// RULE2 - sign extend byte into word; 3B/2S binary, 2B/1S source
// RULE3 - zero extend byte into word; 3B/2S binary, 2B/1S source
// RULE4 - code byte at data pointer plus accumulator to accumulator; 1B, 6 states
// RULE5 - code byte at pc plus accumulator to accumulator; 1B, 6 states
// RULE6 - external read via indirect byte register; 1B, 4S binary, 5S source
// RULE7 - external read via data pointer; 1B, 3 base states
// RULE8 - external write via indirect byte register; 1B, 4 states
// RULE9 - external write via data pointer; 1B, 4 base states
// RULE10 - upper address from region byte, reset to 01h
// RULE11 - code moves and data pointer write add N+1 when external
// RULE12 - data pointer read adds N+2 when external
// RULE13 - wait states stretch the read/write/code strobe, the latch strobe, or both
// RULE14 - opcode mode latched from configuration at reset release
// RULE15 - sources untouched, only destination updated
module mvx_core (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             source_mode_cfg,
    input  wire logic [3:0]       wait_states_cfg,
    input  wire logic             stretch_strobe_cfg,
    input  wire logic             stretch_latch_cfg,
    input  wire logic             code_external,
    input  wire logic             region_we,
    input  wire logic [7:0]       region_wdata,
    input  wire logic             req_valid,
    input  wire mvx_pkg::mvx_req_t req,
    output logic                  req_ready,
    output logic                  res_valid,
    output mvx_pkg::mvx_res_t     res,
    output logic [7:0]            extended_region_byte,
    output logic [23:0]           ext_addr,
    output logic [7:0]            ext_wdata,
    output logic                  ext_data_oe,
    input  wire logic [7:0]       ext_rdata,
    output logic                  addr_latch_strobe,
    output logic                  program_store_strobe_n,
    output logic                  read_strobe_n,
    output logic                  write_strobe_n,
    output logic                  source_mode
);
    import mvx_pkg::*;

    typedef enum {MVX_IDLE, MVX_LATCH, MVX_STROBE, MVX_DONE} mvx_state_t;

    mvx_state_t  state_reg, state_next;
    logic        mode_captured_reg, mode_captured_next;
    logic        source_mode_reg, source_mode_next;
    logic [7:0]  region_reg, region_next;
    logic [4:0]  count_reg, count_next;
    logic [3:0]  wait_reg, wait_next;
    logic [23:0] addr_reg, addr_next;
    logic [7:0]  wdata_reg, wdata_next;
    logic        oe_reg, oe_next;
    logic        ale_reg, ale_next;
    logic        program_store_strobe_n_reg, program_store_strobe_n_next;
    logic        rd_n_reg, rd_n_next;
    logic        wr_n_reg, wr_n_next;
    logic        valid_reg, valid_next;
    mvx_res_t    res_reg, res_next;
    mvx_op_t     op_reg, op_next;

    // pick binary or source figure
    function automatic logic [4:0] mvx_pick(input logic src, input logic [4:0] b,
                                            input logic [4:0] s);
        return src ? s : b;
    endfunction

    // strobe and latch stretch lengths shared by all external phases
    function automatic logic [3:0] mvx_stretch(input logic en, input logic [3:0] n);
        return en ? n : 4'h0;
    endfunction

    // memory access reaches the bus only when the space is external
    function automatic logic mvx_is_ext(input mvx_op_t op, input logic code_ext);
        return (op == MVX_OP_CODE_DP || op == MVX_OP_CODE_PC) ? code_ext :
               (op == MVX_OP_RD_IND || op == MVX_OP_RD_DP ||
                op == MVX_OP_WR_IND || op == MVX_OP_WR_DP);
    endfunction

    assign req_ready              = (state_reg == MVX_IDLE) && mode_captured_reg;
    assign res_valid              = valid_reg;
    assign res                    = res_reg;
    assign extended_region_byte   = region_reg;
    assign ext_addr               = addr_reg;
    assign ext_wdata              = wdata_reg;
    assign ext_data_oe            = oe_reg;
    assign addr_latch_strobe      = ale_reg;
    assign program_store_strobe_n = program_store_strobe_n_reg;
    assign read_strobe_n          = rd_n_reg;
    assign write_strobe_n         = wr_n_reg;
    assign source_mode            = source_mode_reg;

    // next-state for sequencer, mode capture, region and bus pins
    always_comb begin
        logic       ext;
        logic [4:0] base;
        logic [4:0] extra;
        ext                = 1'b0;
        base               = 5'h00;
        extra              = 5'h00;
        state_next         = state_reg;
        mode_captured_next = 1'b1;
        source_mode_next   = mode_captured_reg ? source_mode_reg : source_mode_cfg; // RULE14
        region_next        = region_we ? region_wdata : region_reg;
        count_next         = count_reg;
        wait_next          = wait_reg;
        addr_next          = addr_reg;
        wdata_next         = wdata_reg;
        oe_next            = oe_reg;
        ale_next           = 1'b0;
        program_store_strobe_n_next        = 1'b1;
        rd_n_next          = 1'b1;
        wr_n_next          = 1'b1;
        valid_next         = 1'b0;
        res_next           = res_reg;
        op_next            = op_reg;
        case (state_reg)
            MVX_IDLE: begin
                oe_next = 1'b0;
                if (req_valid && req_ready && req.op != MVX_OP_NONE) begin
                    op_next  = req.op;
                    ext      = mvx_is_ext(req.op, code_external);
                    res_next = '0; // RULE15
                    case (req.op)
                        MVX_OP_HIGH_IMM: begin
                            res_next.dword_we = 1'b1;
                            res_next.dword    = {req.imm, req.dword_src[15:0]}; // RULE1
                            res_next.length   = source_mode_reg ? MVX_LEN_HIGH_SRC
                                                                : MVX_LEN_HIGH_BIN;
                            base = mvx_pick(source_mode_reg, MVX_ST_HIGH_BIN,
                                            MVX_ST_HIGH_SRC); // RULE1
                        end
                        MVX_OP_SIGN_EXT, MVX_OP_ZERO_EXT: begin
                            res_next.word_we = 1'b1;
                            res_next.word    = (req.op == MVX_OP_SIGN_EXT) ?
                                {{8{req.byte_src[MVX_SIGN_BIT]}}, req.byte_src} : // RULE2
                                {8'h00, req.byte_src}; // RULE3
                            res_next.length  = source_mode_reg ? MVX_LEN_EXT_SRC
                                                               : MVX_LEN_EXT_BIN;
                            base = mvx_pick(source_mode_reg, MVX_ST_EXT_BIN,
                                            MVX_ST_EXT_SRC); // RULE2 RULE3
                        end
                        MVX_OP_CODE_DP: begin
                            addr_next = {region_reg, 16'(req.data_pointer + 16'(req.accumulator))}; // RULE4
                            base      = MVX_ST_CODE; // RULE4
                            extra     = 5'(wait_states_cfg + MVX_WAIT_ONE); // RULE11
                        end
                        MVX_OP_CODE_PC: begin
                            addr_next = {region_reg, 16'(req.pc + 16'(req.accumulator))}; // RULE5
                            base      = MVX_ST_CODE; // RULE5
                            extra     = 5'(wait_states_cfg + MVX_WAIT_ONE); // RULE11
                        end
                        MVX_OP_RD_IND: begin
                            addr_next = {region_reg, 8'h00, req.indirect_byte_register}; // RULE10
                            base = mvx_pick(source_mode_reg, MVX_ST_RD_IND_B,
                                            MVX_ST_RD_IND_S); // RULE6
                        end
                        MVX_OP_RD_DP: begin
                            addr_next = {region_reg, req.data_pointer}; // RULE10
                            base      = MVX_ST_RD_DP; // RULE7
                            extra     = 5'(wait_states_cfg + MVX_WAIT_TWO); // RULE12
                        end
                        MVX_OP_WR_IND: begin
                            addr_next  = {region_reg, 8'h00, req.indirect_byte_register};
                            wdata_next = req.accumulator;
                            base       = MVX_ST_WR; // RULE8
                        end
                        MVX_OP_WR_DP: begin
                            addr_next  = {region_reg, req.data_pointer};
                            wdata_next = req.accumulator;
                            base       = MVX_ST_WR; // RULE9
                            extra      = 5'(wait_states_cfg + MVX_WAIT_ONE); // RULE11
                        end
                        default: begin
                            base = MVX_ST_EXT_SRC;
                        end
                    endcase
                    if (req.op == MVX_OP_CODE_DP || req.op == MVX_OP_CODE_PC ||
                        req.op == MVX_OP_RD_IND || req.op == MVX_OP_RD_DP ||
                        req.op == MVX_OP_WR_IND || req.op == MVX_OP_WR_DP)
                        res_next.length = MVX_LEN_ONE; // RULE4 RULE5 RULE6 RULE7 RULE8 RULE9
                    res_next.states = 5'(base + (ext ? extra : 5'h00));
                    if (ext) begin
                        state_next = MVX_LATCH;
                        ale_next   = 1'b1;
                        wait_next  = mvx_stretch(stretch_latch_cfg, wait_states_cfg); // RULE13
                    end else begin
                        if (req.op == MVX_OP_CODE_DP || req.op == MVX_OP_CODE_PC) begin
                            res_next.acc_we      = 1'b1;
                            res_next.accumulator = ext_rdata;
                        end
                        state_next = MVX_DONE;
                    end
                    count_next = 5'(res_next.states - 5'h01);
                end
            end
            MVX_LATCH: begin
                if (wait_reg != 4'h0) begin
                    ale_next  = 1'b1; // RULE13
                    wait_next = 4'(wait_reg - 4'h1);
                end else begin
                    state_next = MVX_STROBE;
                    oe_next    = (op_reg == MVX_OP_WR_IND || op_reg == MVX_OP_WR_DP);
                    wait_next  = mvx_stretch(stretch_strobe_cfg, wait_states_cfg); // RULE13
                    program_store_strobe_n_next = !(op_reg == MVX_OP_CODE_DP || op_reg == MVX_OP_CODE_PC);
                    rd_n_next   = !(op_reg == MVX_OP_RD_IND || op_reg == MVX_OP_RD_DP);
                    wr_n_next   = !oe_next;
                end
                count_next = (count_reg != 5'h00) ? 5'(count_reg - 5'h01) : count_reg;
            end
            MVX_STROBE: begin
                if (wait_reg != 4'h0) begin
                    program_store_strobe_n_next = program_store_strobe_n_reg; // RULE13
                    rd_n_next   = rd_n_reg;
                    wr_n_next   = wr_n_reg;
                    wait_next   = 4'(wait_reg - 4'h1);
                end else begin
                    if (op_reg != MVX_OP_WR_IND && op_reg != MVX_OP_WR_DP) begin
                        res_next.acc_we      = 1'b1;
                        res_next.accumulator = ext_rdata;
                    end
                    state_next = MVX_DONE;
                end
                count_next = (count_reg != 5'h00) ? 5'(count_reg - 5'h01) : count_reg;
            end
            MVX_DONE: begin
                if (count_reg != 5'h00) begin
                    count_next = 5'(count_reg - 5'h01);
                end else begin
                    oe_next    = 1'b0;
                    valid_next = 1'b1;
                    state_next = MVX_IDLE;
                end
            end
            default: begin
                state_next = MVX_IDLE;
            end
        endcase
    end

    // register all state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg         <= MVX_IDLE;
            mode_captured_reg <= 1'b0;
            source_mode_reg   <= 1'b0;
            region_reg        <= MVX_REGION_RESET; // RULE10
            count_reg         <= 5'h00;
            wait_reg          <= 4'h0;
            addr_reg          <= 24'h000000;
            wdata_reg         <= 8'h00;
            oe_reg            <= 1'b0;
            ale_reg           <= 1'b0;
            program_store_strobe_n_reg        <= 1'b1;
            rd_n_reg          <= 1'b1;
            wr_n_reg          <= 1'b1;
            valid_reg         <= 1'b0;
            res_reg           <= '0;
            op_reg            <= MVX_OP_NONE;
        end else begin
            state_reg         <= state_next;
            mode_captured_reg <= mode_captured_next;
            source_mode_reg   <= source_mode_next;
            region_reg        <= region_next;
            count_reg         <= count_next;
            wait_reg          <= wait_next;
            addr_reg          <= addr_next;
            wdata_reg         <= wdata_next;
            oe_reg            <= oe_next;
            ale_reg           <= ale_next;
            program_store_strobe_n_reg        <= program_store_strobe_n_next;
            rd_n_reg          <= rd_n_next;
            wr_n_reg          <= wr_n_next;
            valid_reg         <= valid_next;
            res_reg           <= res_next;
            op_reg            <= op_next;
        end
    end
endmodule

// [logic/mvx_pkg.sv]
/*
 * shared constants and carrier types for the move execution unit.
 * assumes a single 25 MHz core clock and no software-visible registers.
 */
package mvx_pkg;
    // operation codes presented by the decoder
    typedef enum logic [3:0] {
        MVX_OP_NONE,
        MVX_OP_HIGH_IMM,
        MVX_OP_SIGN_EXT,
        MVX_OP_ZERO_EXT,
        MVX_OP_CODE_DP,
        MVX_OP_CODE_PC,
        MVX_OP_RD_IND,
        MVX_OP_RD_DP,
        MVX_OP_WR_IND,
        MVX_OP_WR_DP
    } mvx_op_t;

    // instruction request from the decoder
    typedef struct packed {
        mvx_op_t     op;
        logic [15:0] imm;
        logic [7:0]  byte_src;
        logic [31:0] dword_src;
        logic [15:0] data_pointer;
        logic [15:0] pc;
        logic [7:0]  accumulator;
        logic [7:0]  indirect_byte_register;
    } mvx_req_t;

    // result handed back to the register file
    typedef struct packed {
        logic        acc_we;
        logic [7:0]  accumulator;
        logic        word_we;
        logic [15:0] word;
        logic        dword_we;
        logic [31:0] dword;
        logic [3:0]  length;
        logic [4:0]  states;
    } mvx_res_t;

    localparam logic [7:0] MVX_REGION_RESET = 8'h01;
    localparam int         MVX_SIGN_BIT     = 7;
    localparam logic [3:0] MVX_WAIT_ONE     = 4'h1;
    localparam logic [3:0] MVX_WAIT_TWO     = 4'h2;
    // lengths in bytes
    localparam logic [3:0] MVX_LEN_HIGH_BIN = 4'h5;
    localparam logic [3:0] MVX_LEN_HIGH_SRC = 4'h4;
    localparam logic [3:0] MVX_LEN_EXT_BIN  = 4'h3;
    localparam logic [3:0] MVX_LEN_EXT_SRC  = 4'h2;
    localparam logic [3:0] MVX_LEN_ONE      = 4'h1;
    // base state counts
    localparam logic [4:0] MVX_ST_HIGH_BIN  = 5'h03;
    localparam logic [4:0] MVX_ST_HIGH_SRC  = 5'h02;
    localparam logic [4:0] MVX_ST_EXT_BIN   = 5'h02;
    localparam logic [4:0] MVX_ST_EXT_SRC   = 5'h01;
    localparam logic [4:0] MVX_ST_CODE      = 5'h06;
    localparam logic [4:0] MVX_ST_RD_IND_B  = 5'h04;
    localparam logic [4:0] MVX_ST_RD_IND_S  = 5'h05;
    localparam logic [4:0] MVX_ST_RD_DP     = 5'h03;
    localparam logic [4:0] MVX_ST_WR        = 5'h04;
endpackage

// [test/mvx_core_assertions.sv]
/*
 * concurrent checks on the ports of the move execution unit.
 * assumes one clock domain and the carrier types of mvx_pkg.
 */
`timescale 1ns/1ps
module mvx_core_checker
    import mvx_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic [3:0]  wait_states_cfg,
    input wire logic        stretch_strobe_cfg,
    input wire logic        stretch_latch_cfg,
    input wire logic        code_external,
    input wire logic        req_valid,
    input wire mvx_req_t    req,
    input wire logic        req_ready,
    input wire logic        res_valid,
    input wire mvx_res_t    res,
    input wire logic [7:0]  extended_region_byte,
    input wire logic [23:0] ext_addr,
    input wire logic        addr_latch_strobe,
    input wire logic        program_store_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic        source_mode
);
    logic [4:0]  cnt_reg, low_cnt_reg, ale_cnt_reg, n1, n2;
    logic [3:0]  nw_reg;
    logic        ss_reg, sl_reg, cx_reg, take, strobe_low;
    mvx_req_t    rq_reg;
    mvx_op_t     op;
    logic [15:0] exp_addr;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // request taken, strobes active, extra wait counts
    assign take = req_valid && req_ready && (req.op != MVX_OP_NONE);
    assign strobe_low = !(program_store_strobe_n && read_strobe_n && write_strobe_n);
    assign op = rq_reg.op;
    assign n1 = {1'b0, nw_reg} + 5'h01;
    assign n2 = {1'b0, nw_reg} + 5'h02;
    assign exp_addr = (op == MVX_OP_CODE_PC) ? rq_reg.pc + {8'h00, rq_reg.accumulator} :
                      (op == MVX_OP_CODE_DP) ? rq_reg.data_pointer + {8'h00, rq_reg.accumulator} :
                      (op inside {MVX_OP_RD_IND, MVX_OP_WR_IND}) ?
                      {8'h00, rq_reg.indirect_byte_register} : rq_reg.data_pointer;
    // snapshot of the taken request and cycle counters
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            {cnt_reg, low_cnt_reg, ale_cnt_reg} <= 15'h0000;
            {nw_reg, ss_reg, sl_reg, cx_reg} <= 7'h00;
            rq_reg <= '0;
        end else begin
            cnt_reg <= take ? 5'h00 : ((cnt_reg == 5'h1F) ? cnt_reg : cnt_reg + 5'h01);
            low_cnt_reg <= strobe_low ? low_cnt_reg + 5'h01 : 5'h00;
            ale_cnt_reg <= addr_latch_strobe ? ale_cnt_reg + 5'h01 : 5'h00;
            if (take) begin
                rq_reg <= req;
                {nw_reg, ss_reg, sl_reg, cx_reg} <= {wait_states_cfg, stretch_strobe_cfg,
                                                     stretch_latch_cfg, code_external};
            end
        end
    end
    sequence s_strobe_end;
        strobe_low ##1 !strobe_low;
    endsequence
    sequence s_latch_end;
        addr_latch_strobe ##1 !addr_latch_strobe;
    endsequence
    a_region_reset_value: assert property ($rose(reset_n) |-> extended_region_byte == 8'h01)
        else $error("region byte not 01 after reset");
    a_mode_held: assert property ($past(reset_n, 2) |-> $stable(source_mode))
        else $error("opcode mode changed after reset");
    a_answer_timing: assert property (res_valid |-> cnt_reg == res.states)
        else $error("answer not after stated count");
    a_high_word: assert property (res_valid && op == MVX_OP_HIGH_IMM |-> res.dword_we
        && res.dword == {rq_reg.imm, rq_reg.dword_src[15:0]} && res.length == (source_mode ? 4'h4 : 4'h5))
        else $error("high word move wrong");
    a_extend_word: assert property (res_valid && op inside {MVX_OP_SIGN_EXT, MVX_OP_ZERO_EXT}
        |-> res.word_we && res.states == (source_mode ? 5'h01 : 5'h02) && res.word == {((op ==
        MVX_OP_SIGN_EXT) ? {8{rq_reg.byte_src[7]}} : 8'h00), rq_reg.byte_src})
        else $error("extending move wrong");
    a_read_counts: assert property (res_valid && op inside {MVX_OP_RD_IND, MVX_OP_RD_DP}
        |-> res.acc_we && res.length == 4'h1 && res.states == ((op == MVX_OP_RD_DP) ? 5'h03 + n2 :
        (source_mode ? 5'h05 : 5'h04)))
        else $error("external read counts wrong");
    a_write_counts: assert property (res_valid && op inside {MVX_OP_WR_IND, MVX_OP_WR_DP}
        |-> !res.acc_we && !res.word_we && !res.dword_we
        && res.states == ((op == MVX_OP_WR_DP) ? 5'h04 + n1 : 5'h04))
        else $error("external write counts wrong");
    a_code_counts: assert property (res_valid && op inside {MVX_OP_CODE_DP, MVX_OP_CODE_PC}
        |-> res.acc_we && res.length == 4'h1 && res.states == 5'h06 + (cx_reg ? n1 : 5'h00))
        else $error("code move counts wrong");
    a_data_address: assert property (!read_strobe_n || !write_strobe_n
        |-> ext_addr == {extended_region_byte, exp_addr})
        else $error("data address wrong");
    a_code_address: assert property (!program_store_strobe_n |-> ext_addr[15:0] == exp_addr)
        else $error("code address wrong");
    a_strobe_stretch: assert property (s_strobe_end |-> low_cnt_reg == (ss_reg ? n1 : 5'h01))
        else $error("strobe width wrong");
    a_latch_stretch: assert property (s_latch_end |-> ale_cnt_reg == (sl_reg ? n1 : 5'h01))
        else $error("latch strobe width wrong");
endmodule

bind mvx_core mvx_core_checker i_mvx_core_checker (.*);

// [test/mvx_ext_memory.sv]
/*
 * behavioural external code and data memory on the multiplexed bus.
 * assumes it shares the core clock; low eight address bits select a byte.
 */
`timescale 1ns/1ps
module mvx_ext_memory (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic [23:0] ext_addr,
    input wire logic [7:0]  ext_wdata,
    input wire logic        ext_data_oe,
    input wire logic        program_store_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    output logic [7:0]      ext_rdata
);
    logic [7:0] mem [0:255];
    logic       flip_reg;
    // released bus shows a pattern changing every cycle
    always_ff @(posedge clock or negedge reset_n) begin
        flip_reg <= reset_n ? ~flip_reg : 1'b0;
    end
    // byte lands while the write strobe and data drive are active
    always_ff @(posedge clock) begin
        if (!write_strobe_n && ext_data_oe) begin
            mem[ext_addr[7:0]] <= ext_wdata;
        end
    end
    assign ext_rdata = (!read_strobe_n || !program_store_strobe_n) ? mem[ext_addr[7:0]] :
                       (flip_reg ? 8'hA5 : 8'h5A);
endmodule

// [test/testbench.sv]
/*
 * self-checking bench for the move execution unit with an external memory model.
 * assumes the checker is bound in; runs binary mode with wait settings 0 and 1, source mode with wait setting 1 only.
 */
`timescale 1ns/1ps
module testbench;
    import mvx_pkg::*;
    logic clock, reset_n, source_mode_cfg, stretch_strobe_cfg, stretch_latch_cfg, code_external;
    logic region_we, req_valid, req_ready, res_valid, ext_data_oe, addr_latch_strobe;
    logic program_store_strobe_n, read_strobe_n, write_strobe_n, source_mode;
    logic [3:0] wait_states_cfg;
    logic [7:0] region_wdata, extended_region_byte, ext_wdata, ext_rdata;
    logic [23:0] ext_addr;
    mvx_req_t req, rq;
    mvx_res_t res;
    int fails, total_checks, cycles;
    // both stretches together overrun the fixed indirect-form budget, so never combined
    logic [3:0] cfg [4] = '{4'b0000, 4'b1101, 4'b0101, 4'b1110};
    mvx_core i_mvx_core (.*);
    mvx_ext_memory i_mvx_ext_memory (.*);
    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end
    task automatic close_out();
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one request held until taken, then wait for the answer
    task automatic run(input logic [4:0] est);
        int n;
        n = 0;
        req = rq;
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge clock);
            #1;
            n++;
        end
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        n = 0;
        while (res_valid !== 1'b1 && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("latency", {27'h0, est}, n);
        chk("states", {27'h0, est}, {27'h0, res.states});
    endtask
    task automatic do_reset(input logic sm);
        reset_n = 1'b0;
        source_mode_cfg = sm;
        repeat (2) @(posedge clock);
        #1 reset_n = 1'b1;
        @(posedge clock);
        #1;
        chk("region", 32'h01, {24'h0, extended_region_byte});
        chk("mode", {31'h0, sm}, {31'h0, source_mode});
    endtask
    task automatic t_reg_moves(input logic sm);
        rq = '0;
        rq.op = MVX_OP_HIGH_IMM;
        rq.imm = 16'hBEEF;
        rq.dword_src = 32'h1234_5678;
        rq.byte_src = 8'h9C;
        run(sm ? 5'h02 : 5'h03);
        chk("dword", 32'hBEEF_5678, res.dword);
        chk("hlen", sm ? 32'h4 : 32'h5, {28'h0, res.length});
        rq.op = MVX_OP_SIGN_EXT;
        run(sm ? 5'h01 : 5'h02);
        chk("sword", 32'hFF9C, {16'h0, res.word});
        chk("slen", sm ? 32'h2 : 32'h3, {28'h0, res.length});
        rq.op = MVX_OP_ZERO_EXT;
        run(sm ? 5'h01 : 5'h02);
        chk("zword", 32'h009C, {16'h0, res.word});
        chk("wes", 32'h2, {29'h0, res.acc_we, res.word_we, res.dword_we});
    endtask
    task automatic t_ext_moves(input logic sm, input logic [4:0] nw);
        rq = '0;
        rq.op = MVX_OP_WR_IND;
        rq.accumulator = 8'h3A;
        rq.indirect_byte_register = 8'h21;
        run(5'h04);
        chk("mem21", 32'h3A, {24'h0, i_mvx_ext_memory.mem[8'h21]});
        rq.op = MVX_OP_RD_IND;
        rq.accumulator = 8'h00;
        run(sm ? 5'h05 : 5'h04);
        chk("acc_ri", 32'h3A, {24'h0, res.accumulator});
        rq.op = MVX_OP_WR_DP;
        rq.data_pointer = 16'h0042;
        rq.accumulator = 8'hC5;
        run(5'h05 + nw);
        chk("mem42", 32'hC5, {24'h0, i_mvx_ext_memory.mem[8'h42]});
        rq.op = MVX_OP_RD_DP;
        run(5'h05 + nw);
        chk("acc_dp", 32'hC5, {24'h0, res.accumulator});
    endtask
    task automatic t_code(input logic [4:0] nw);
        i_mvx_ext_memory.mem[8'h15] = 8'h6E;
        i_mvx_ext_memory.mem[8'h32] = 8'h91;
        code_external = 1'b1;
        rq = '0;
        rq.op = MVX_OP_CODE_DP;
        rq.data_pointer = 16'h0010;
        rq.accumulator = 8'h05;
        run(5'h07 + nw);
        chk("acc_cdp", 32'h6E, {24'h0, res.accumulator});
        rq.op = MVX_OP_CODE_PC;
        rq.pc = 16'h0030;
        rq.accumulator = 8'h02;
        run(5'h07 + nw);
        chk("acc_cpc", 32'h91, {24'h0, res.accumulator});
        code_external = 1'b0;
        run(5'h06);
    endtask
    task automatic t_region();
        region_we = 1'b1;
        region_wdata = 8'h3C;
        @(posedge clock);
        #1 region_we = 1'b0;
        chk("region_new", 32'h3C, {24'h0, extended_region_byte});
        rq = '0;
        rq.op = MVX_OP_WR_IND;
        rq.accumulator = 8'h77;
        rq.indirect_byte_register = 8'h08;
        run(5'h04);
        chk("mem08", 32'h77, {24'h0, i_mvx_ext_memory.mem[8'h08]});
    endtask
    // main sequence over opcode modes, waits and stretch choices
    initial begin
        {reset_n, source_mode_cfg, stretch_strobe_cfg, stretch_latch_cfg} = 4'h0;
        {code_external, region_we, req_valid, region_wdata, wait_states_cfg} = 15'h0000;
        req = '0;
        rq = '0;
        fails = 0;
        total_checks = 0;
        cycles = 0;
        foreach (cfg[k]) begin
            {stretch_strobe_cfg, stretch_latch_cfg} = cfg[k][1:0];
            wait_states_cfg = {3'h0, cfg[k][2]};
            do_reset(cfg[k][3]);
            t_reg_moves(cfg[k][3]);
            t_ext_moves(cfg[k][3], {4'h0, cfg[k][2]});
            t_code({4'h0, cfg[k][2]});
        end
        t_region();
        close_out();
    end
endmodule
